// >>> logic/sscr_regs.sv
// customer setup register bank with apb access and setpoint linearizer
//
// Summary of operation
// - two 16-bit writable setup words
// - front-end bit 15 is write protect
// - front-end bits 7:6 pick angle wrap
// - front-end bits 5:4 pick sample rate
// - variant one decodes setup code bits 3:0
// - variant two: 0010 is 3b, 0101 reserved
// - input gain is coefficient times 2^n
// - segment slope is coefficient times 2^(k+1)
// - datapath bit 0 picks fixed or variable knots
// - fixed knots spread evenly over input span
// - output interpolates between bracketing knots
module sscr_regs
    import sscr_pkg::*;
#(
    parameter bit VARIANT = 1'b0  // 0 first product variant, 1 second
) (
    input wire logic pclk,              // bus clock
    input wire logic presetn,           // async reset, active low
    input wire logic psel,              // apb select
    input wire logic penable,           // apb access phase
    input wire logic pwrite,            // apb direction
    input wire logic [11:0] paddr,      // apb byte address
    input wire logic [31:0] pwdata,     // apb write data
    output logic [31:0] prdata,         // apb read data
    output logic pready,                // apb ready
    output logic pslverr,               // apb error, unmapped address
    input wire logic lock_clear,        // privileged unlock pulse
    input wire logic [15:0] raw_in,     // signed position sample
    output logic [15:0] lin_out,        // linearized result
    output logic cfg_locked,            // bank write protected
    output logic [1:0] wrap_sel,        // angle wrap code
    output logic [8:0] wrap_deg,        // angle wrap in degrees
    output logic [4:0] sample_ksps,     // converter rate in ksps
    output logic [2:0] setup_sel,       // decoded measurement setup
    output logic setup_reserved,        // setup code not usable
    output logic [2:0] gain_exp,        // input gain exponent
    output logic [3:0] slope_exp,       // slope gain exponent
    output logic knot_var_mode          // programmable knot positions
);

    typedef struct packed {
        logic [15:0] fe;
        logic [15:0] dp;
        logic [15:0] gain;
        logic [SSCR_KNOTS-1:0][15:0] ky;
        logic [SSCR_KNOTS-1:0][15:0] kx;
        logic [SSCR_SEGS-1:0][15:0] slope;
        logic [31:0] rdata;
        logic [15:0] scaled;
        sscr_setup_type setup;
    } sscr_state_type;

    sscr_state_type q, d;

    sscr_lin_if lif ();

    // true when addr falls in a bank of n words starting at base
    function automatic logic in_bank(input logic [11:0] addr,
                                     input logic [11:0] base,
                                     input int n);
        logic [11:0] rel;
        rel = addr - base;
        return (addr >= base) && (rel[1:0] == 2'b00)
               && (int'(rel[11:2]) < n);
    endfunction

    function automatic logic [4:0] bank_idx(input logic [11:0] addr,
                                            input logic [11:0] base);
        logic [11:0] rel;
        rel = addr - base;
        return rel[6:2];
    endfunction

    // the two variants differ only in codes 0010, 0011 and 0101
    function automatic sscr_setup_type decode_setup(input logic [3:0] c);
        sscr_setup_type s;
        s = SSCR_SU_RSVD;
        unique case (c)
            4'h0, 4'h1: s = SSCR_SU_4A;
            4'h2: s = VARIANT ? SSCR_SU_3B : SSCR_SU_4A;
            4'h3: s = VARIANT ? SSCR_SU_RSVD : SSCR_SU_3B;
            4'h4: s = SSCR_SU_3A;
            4'h5: s = VARIANT ? SSCR_SU_RSVD : SSCR_SU_4B_VC;
            4'h6: s = SSCR_SU_ROT180;
            4'h7: s = SSCR_SU_ROT360;
            default: s = SSCR_SU_RSVD;
        endcase
        return s;
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        return (a == SSCR_FE_OFS) || (a == SSCR_DP_OFS)
            || (a == SSCR_GAIN_OFS) || (a == SSCR_STAT_OFS)
            || (a == SSCR_SCALED_OFS) || (a == SSCR_LOUT_OFS)
            || in_bank(a, SSCR_KY_BASE, SSCR_KNOTS)
            || in_bank(a, SSCR_KX_BASE, SSCR_KNOTS)
            || in_bank(a, SSCR_SLOPE_BASE, SSCR_SEGS);
    endfunction

    always_comb begin
        logic wr;
        logic rd;
        logic [15:0] wd;
        logic [4:0] idx;
        logic signed [49:0] ga;
        logic signed [49:0] gb;
        logic [2:0] n;
        d = q;
        wd = pwdata[15:0];
        idx = 5'h00;
        n = q.dp[SSCR_DP_NMULT_LSB +: 3];
        ga = sscr_sext(raw_in);
        gb = sscr_sext(q.gain);
        // writes land only on the access edge of an unprotected bank
        wr = psel && penable && pwrite && mapped(paddr)
             && !q.fe[SSCR_FE_LOCK_BIT];
        rd = psel && !penable && !pwrite;

        // unlock first; a same-cycle write setting the lock is refused while locked, so the unlock wins
        if (lock_clear) begin
            d.fe[SSCR_FE_LOCK_BIT] = 1'b0;
        end

        if (wr) begin
            if (paddr == SSCR_FE_OFS) begin
                // bits 14:8 are kept at zero
                d.fe = wd & SSCR_FE_WMASK;
            end else if (paddr == SSCR_DP_OFS) begin
                d.dp = wd & SSCR_DP_WMASK;
            end else if (paddr == SSCR_GAIN_OFS) begin
                d.gain = wd;
            end else if (in_bank(paddr, SSCR_KY_BASE, SSCR_KNOTS)) begin
                idx = bank_idx(paddr, SSCR_KY_BASE);
                d.ky[idx] = wd;
            end else if (in_bank(paddr, SSCR_KX_BASE, SSCR_KNOTS)) begin
                idx = bank_idx(paddr, SSCR_KX_BASE);
                d.kx[idx] = wd;
            end else if (in_bank(paddr, SSCR_SLOPE_BASE, SSCR_SEGS)) begin
                idx = bank_idx(paddr, SSCR_SLOPE_BASE);
                d.slope[idx] = wd;
            end
        end

        d.setup = decode_setup(d.fe[SSCR_FE_SETUP_LSB +: 4]);

        // prdata is captured in the setup phase so the access phase
        // can finish with no wait state
        if (rd) begin
            d.rdata = 32'h0000_0000;
            if (paddr == SSCR_FE_OFS) begin
                d.rdata = {16'h0000, q.fe};
            end else if (paddr == SSCR_DP_OFS) begin
                d.rdata = {16'h0000, q.dp};
            end else if (paddr == SSCR_GAIN_OFS) begin
                d.rdata = {16'h0000, q.gain};
            end else if (paddr == SSCR_STAT_OFS) begin
                d.rdata = {25'h0, q.setup, 2'b00,
                           (q.setup == SSCR_SU_RSVD),
                           q.fe[SSCR_FE_LOCK_BIT]};
            end else if (paddr == SSCR_SCALED_OFS) begin
                d.rdata = {16'h0000, q.scaled};
            end else if (paddr == SSCR_LOUT_OFS) begin
                d.rdata = {16'h0000, lif.out_val};
            end else if (in_bank(paddr, SSCR_KY_BASE, SSCR_KNOTS)) begin
                d.rdata = {16'h0000, q.ky[bank_idx(paddr, SSCR_KY_BASE)]};
            end else if (in_bank(paddr, SSCR_KX_BASE, SSCR_KNOTS)) begin
                d.rdata = {16'h0000, q.kx[bank_idx(paddr, SSCR_KX_BASE)]};
            end else if (in_bank(paddr, SSCR_SLOPE_BASE, SSCR_SEGS)) begin
                d.rdata = {16'h0000,
                           q.slope[bank_idx(paddr, SSCR_SLOPE_BASE)]};
            end
        end

        // coefficient is a fraction below one, so 2^7 gives gain below 128
        d.scaled = sscr_sat16(((ga * gb) <<< n)
                              >>> SSCR_GAIN_SHIFT);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.fe <= SSCR_FE_RST;
            q.dp <= SSCR_DP_RST;
            q.gain <= SSCR_GAIN_RST;
            q.ky <= {SSCR_KNOTS{SSCR_KNOT_RST}};
            q.kx <= {SSCR_KNOTS{SSCR_KNOT_RST}};
            q.slope <= {SSCR_SEGS{SSCR_KNOT_RST}};
            q.rdata <= 32'h0000_0000;
            q.scaled <= 16'h0000;
            q.setup <= SSCR_SU_4A;
        end else begin
            q <= d;
        end
    end

    assign lif.var_mode = q.dp[SSCR_DP_VAR_BIT];
    assign lif.slope_exp = q.dp[SSCR_DP_NSP_LSB +: 4];
    assign lif.in_val = q.scaled;
    assign lif.knot_y = q.ky;
    assign lif.knot_x = q.kx;
    assign lif.slope = q.slope;

    sscr_lin_core u_core (
        .pclk(pclk),
        .presetn(presetn),
        .lif(lif.core)
    );

    // zero wait state slave; only unmapped addresses are refused,
    // a write into a protected bank completes but is dropped
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = q.rdata;

    assign lin_out = lif.out_val;
    assign cfg_locked = q.fe[SSCR_FE_LOCK_BIT];
    assign wrap_sel = q.fe[SSCR_FE_WRAP_LSB +: 2];
    assign wrap_deg = SSCR_WRAP_DEG[q.fe[SSCR_FE_WRAP_LSB +: 2]];
    assign sample_ksps = SSCR_RATE_KSPS[q.fe[SSCR_FE_RATE_LSB +: 2]];
    assign setup_sel = q.setup;
    assign setup_reserved = (q.setup == SSCR_SU_RSVD);
    assign gain_exp = q.dp[SSCR_DP_NMULT_LSB +: 3];
    assign slope_exp = q.dp[SSCR_DP_NSP_LSB +: 4];
    assign knot_var_mode = q.dp[SSCR_DP_VAR_BIT];

endmodule

// >>> logic/sscr_pkg.sv
// constants, types and helpers shared by the setup register bank
package sscr_pkg;

    localparam int SSCR_KNOTS = 17;
    localparam int SSCR_SEGS = 16;

    localparam logic [11:0] SSCR_FE_OFS = 12'h000;
    localparam logic [11:0] SSCR_DP_OFS = 12'h004;
    localparam logic [11:0] SSCR_GAIN_OFS = 12'h008;
    localparam logic [11:0] SSCR_STAT_OFS = 12'h00c;
    localparam logic [11:0] SSCR_SCALED_OFS = 12'h010;
    localparam logic [11:0] SSCR_LOUT_OFS = 12'h014;
    localparam logic [11:0] SSCR_KY_BASE = 12'h100;
    localparam logic [11:0] SSCR_KX_BASE = 12'h180;
    localparam logic [11:0] SSCR_SLOPE_BASE = 12'h200;

    localparam int SSCR_FE_LOCK_BIT = 15;
    localparam int SSCR_FE_WRAP_LSB = 6;
    localparam int SSCR_FE_RATE_LSB = 4;
    localparam int SSCR_FE_SETUP_LSB = 0;
    localparam int SSCR_DP_NMULT_LSB = 5;
    localparam int SSCR_DP_NSP_LSB = 1;
    localparam int SSCR_DP_VAR_BIT = 0;

    localparam logic [15:0] SSCR_FE_WMASK = 16'h80ff;
    localparam logic [15:0] SSCR_DP_WMASK = 16'h00ff;
    localparam logic [15:0] SSCR_FE_RST = 16'h0000;
    localparam logic [15:0] SSCR_DP_RST = 16'h0000;
    localparam logic [15:0] SSCR_GAIN_RST = 16'h7fff;
    localparam logic [15:0] SSCR_KNOT_RST = 16'h0000;

    localparam int SSCR_FIX_SHIFT = 12;
    localparam int SSCR_GAIN_SHIFT = 15;
    localparam int SSCR_SLOPE_SHIFT = 16;

    localparam logic [8:0] SSCR_WRAP_DEG [4] = '{9'h168, 9'h05a, 9'h078, 9'h0b4};
    localparam logic [4:0] SSCR_RATE_KSPS [4] = '{5'h02, 5'h04, 5'h08, 5'h10};

    typedef enum logic [2:0] {
        SSCR_SU_4A, SSCR_SU_3B, SSCR_SU_3A, SSCR_SU_4B_VC,
        SSCR_SU_ROT180, SSCR_SU_ROT360, SSCR_SU_RSVD
    } sscr_setup_type;

    function automatic logic signed [49:0] sscr_sext(input logic [15:0] v);
        return {{34{v[15]}}, v};
    endfunction

    // clip a wide result into the signed 16-bit span
    function automatic logic [15:0] sscr_sat16(input logic signed [49:0] v);
        if (v > 50'sh0_0000_0000_7fff) return 16'h7fff;
        if (v < -50'sh0_0000_0000_8000) return 16'h8000;
        return v[15:0];
    endfunction

endpackage

// >>> logic/sscr_lin_if.sv
// linearizer configuration and result between bank and core
interface sscr_lin_if;
    import sscr_pkg::*;
    logic var_mode;
    logic [3:0] slope_exp;
    logic [15:0] in_val;
    logic [SSCR_KNOTS-1:0][15:0] knot_y;
    logic [SSCR_KNOTS-1:0][15:0] knot_x;
    logic [SSCR_SEGS-1:0][15:0] slope;
    logic [15:0] out_val;
    modport bank (output var_mode, slope_exp, in_val, knot_y, knot_x,
                  slope, input out_val);
    modport core (input var_mode, slope_exp, in_val, knot_y, knot_x,
                  slope, output out_val);
endinterface

// >>> logic/sscr_lin_core.sv
// knot linearizer: picks the bracketing segment and interpolates
module sscr_lin_core
    import sscr_pkg::*;
(
    input wire logic pclk,     // bus clock
    input wire logic presetn,  // async reset, active low
    sscr_lin_if.core lif       // knots in, result out
);

    typedef struct packed {
        logic [15:0] out;
    } sscr_core_type;

    sscr_core_type q, d;

    always_comb begin
        logic [15:0] off;
        logic [4:0] seg;
        logic signed [49:0] base;
        logic signed [49:0] a;
        logic signed [49:0] b;
        logic signed [49:0] acc;
        d = q;
        off = {~lif.in_val[15], lif.in_val[14:0]};
        seg = {1'b0, off[15:12]};
        base = '0;
        a = '0;
        b = '0;
        acc = '0;
        if (!lif.var_mode) begin
            // even spacing over the input span, y values only
            base = sscr_sext(lif.knot_y[seg]);
            a = sscr_sext(lif.knot_y[seg + 5'h01]) - base;
            b = {38'h0, off[11:0]};
            acc = base + ((a * b) >>> SSCR_FIX_SHIFT);
        end else begin
            // knots must be programmed in ascending x order
            seg = 5'h00;
            for (int i = 1; i < SSCR_SEGS; i++) begin
                if ($signed(lif.knot_x[i]) <= $signed(lif.in_val)) begin
                    seg = 5'(i);
                end
            end
            base = sscr_sext(lif.knot_y[seg]);
            a = sscr_sext(lif.in_val) - sscr_sext(lif.knot_x[seg]);
            b = sscr_sext(lif.slope[seg]);
            acc = base + (((a * b) <<< ({1'b0, lif.slope_exp} + 5'h01))
                  >>> SSCR_SLOPE_SHIFT);
        end
        d.out = sscr_sat16(acc);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lif.out_val = q.out;

endmodule

// >>> test/sscr_regs_monitor.sv
// assertion checker on the setup register bank ports
module sscr_regs_monitor
    import sscr_pkg::*;
(
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic lock_clear, // unlock pulse
    input wire logic cfg_locked, // write protected
    input wire logic [1:0] wrap_sel, // wrap code
    input wire logic [8:0] wrap_deg, // wrap in degrees
    input wire logic [4:0] sample_ksps, // sample rate
    input wire logic [2:0] setup_sel, // decoded setup
    input wire logic setup_reserved, // setup unusable
    input wire logic [2:0] gain_exp, // gain exponent
    input wire logic [3:0] slope_exp, // slope exponent
    input wire logic knot_var_mode // knot mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr, fe_wr, dp_wr, fe_any;
    assign wr = psel && penable && pwrite;
    assign fe_any = wr && paddr == SSCR_FE_OFS;
    assign fe_wr = fe_any && !cfg_locked;
    assign dp_wr = wr && paddr == SSCR_DP_OFS && !cfg_locked;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY: assert property (psel && penable |-> pready)
        else $error("ready missing in access phase");
    AST_UPPER: assert property (psel && penable && !pwrite |->
        prdata[31:16] == 16'h0000) else $error("upper read half not zero");
    AST_LOCK_SET: assert property (fe_wr |=>
        cfg_locked == $past(pwdata[15])) else $error("lock bit not written");
    AST_WRAP_WR: assert property (fe_wr |=>
        wrap_sel == $past(pwdata[7:6])) else $error("wrap code not written");
    AST_WRAP_DEG: assert property (wrap_deg == (wrap_sel == 2'h0 ? 9'h168 :
        wrap_sel == 2'h1 ? 9'h05a : wrap_sel == 2'h2 ? 9'h078 : 9'h0b4))
        else $error("wrap degrees wrong");
    AST_RATE_WR: assert property (fe_wr |=>
        sample_ksps == 5'h02 << $past(pwdata[5:4])) else $error("rate wrong");
    AST_DP_WR: assert property (dp_wr |=>
        {gain_exp, slope_exp, knot_var_mode} == $past(pwdata[7:0]))
        else $error("datapath fields not written");
    AST_LOCK_HOLD: assert property (cfg_locked && !lock_clear |=>
        cfg_locked) else $error("lock dropped without unlock");
    AST_LOCK_DROP: assert property (cfg_locked && !lock_clear && wr |=>
        $stable({wrap_sel, sample_ksps, setup_sel, gain_exp, slope_exp,
        knot_var_mode})) else $error("write taken while locked");
    AST_UNLOCK: assert property (cfg_locked && lock_clear && !fe_any |=>
        !cfg_locked) else $error("unlock ignored");
    AST_RSVD: assert property (setup_reserved == (setup_sel == 3'h6))
        else $error("reserved flag mismatch");
endmodule

bind sscr_regs sscr_regs_monitor u_sscr_regs_monitor (.*);

// >>> test/sensor_setup_config_regs_tb_top.sv
// self-checking bench for the setup register bank
module sensor_setup_config_regs_tb_top
    import sscr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, lock_clear = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] raw_in = 16'h0000, lin_out;
    logic pready, pslverr, cfg_locked, setup_reserved, rsvd2, err;
    logic [1:0] wrap_sel;
    logic [8:0] wrap_deg;
    logic [4:0] sample_ksps;
    logic [2:0] setup_sel, setup2, gain_exp;
    logic [3:0] slope_exp;
    logic knot_var_mode;
    logic [8:0] wdeg [4] = '{9'h168, 9'h05a, 9'h078, 9'h0b4};
    logic [2:0] su0 [8] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
    logic [2:0] su1 [8] = '{3'h0, 3'h0, 3'h1, 3'h6, 3'h2, 3'h6, 3'h4, 3'h5};
    int n_mismatch = 0;
    int num_checks = 0;

    sscr_regs u_sscr_regs (.*);
    // second variant shares the bus so both decoders see the same codes
    sscr_regs #(.VARIANT(1'b1)) u_sscr_regs_v2 (.*, .prdata(), .pready(),
        .pslverr(), .lin_out(), .cfg_locked(), .wrap_sel(), .wrap_deg(),
        .sample_ksps(), .setup_sel(setup2), .setup_reserved(rsvd2),
        .gain_exp(), .slope_exp(), .knot_var_mode());

    initial begin
        forever #20 pclk = ~pclk;
    end

    task report_and_stop;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task t_reset;
        rdchk(SSCR_FE_OFS, 32'h0);
        rdchk(SSCR_DP_OFS, 32'h0);
        rdchk(SSCR_GAIN_OFS, 32'h7fff);
        rdchk(12'h030, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask

    task t_frontend;
        logic [15:0] d;
        // only setup codes 0000 to 0111 are ever written
        for (int i = 0; i < 8; i++) begin
            // reserved bits are written as ones and must read back zero
            d = {1'b0, 7'h7f, i[1:0], ~i[1:0], 1'b0, i[2:0]};
            apb(1'b1, SSCR_FE_OFS, {16'h0, d});
            @(negedge pclk);
            chk({23'h0, wrap_deg}, {23'h0, wdeg[i[1:0]]});
            chk({27'h0, sample_ksps}, {27'h0, 5'h02 << d[5:4]});
            chk({29'h0, setup_sel}, {29'h0, su0[i]});
            chk({29'h0, setup2}, {29'h0, su1[i]});
            chk({31'h0, rsvd2}, {31'h0, su1[i] == 3'h6});
            rdchk(SSCR_FE_OFS, {16'h0, d & 16'h80ff});
        end
    endtask

    task t_datapath;
        logic [15:0] dv [2];
        dv = '{16'hff21, 16'h00de};
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, SSCR_DP_OFS, {16'h0, dv[i]});
            @(negedge pclk);
            chk({29'h0, gain_exp}, {29'h0, dv[i][7:5]});
            chk({28'h0, slope_exp}, {28'h0, dv[i][4:1]});
            chk({31'h0, knot_var_mode}, {31'h0, dv[i][0]});
            rdchk(SSCR_DP_OFS, {24'h0, dv[i][7:0]});
        end
    endtask

    task lin(input logic [15:0] x, input logic [15:0] e);
        @(posedge pclk);
        raw_in <= x;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk({16'h0, lin_out}, {16'h0, e});
        rdchk(SSCR_SCALED_OFS, {16'h0, x});
        rdchk(SSCR_LOUT_OFS, {16'h0, e});
    endtask

    task t_linear;
        // gain 0.5 times 2^1 passes the sample through unscaled
        apb(1'b1, SSCR_GAIN_OFS, 32'h4000);
        apb(1'b1, SSCR_DP_OFS, 32'h20);
        for (int i = 0; i < 17; i++) begin
            apb(1'b1, SSCR_KY_BASE + 12'(4 * i), 32'(i * 256));
        end
        lin(16'h1234, 16'h0923);
        lin(16'h8000, 16'h0000);
        lin(16'h7fff, 16'h0fff);
        apb(1'b1, SSCR_DP_OFS, 32'h21);
        lin(16'h1234, 16'h0f00);
    endtask

    task t_lock;
        apb(1'b1, SSCR_FE_OFS, 32'h8040);
        @(negedge pclk);
        chk({31'h0, cfg_locked}, 32'h1);
        // status: setup 4a, not reserved, lock bit set
        rdchk(SSCR_STAT_OFS, 32'h1);
        apb(1'b1, SSCR_FE_OFS, 32'h0080);
        apb(1'b1, SSCR_DP_OFS, 32'h00ff);
        rdchk(SSCR_FE_OFS, 32'h8040);
        rdchk(SSCR_DP_OFS, 32'h21);
        @(posedge pclk);
        lock_clear <= 1'b1;
        @(posedge pclk);
        lock_clear <= 1'b0;
        @(negedge pclk);
        chk({31'h0, cfg_locked}, 32'h0);
        apb(1'b1, SSCR_FE_OFS, 32'h0080);
        rdchk(SSCR_FE_OFS, 32'h0080);
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_frontend();
        t_datapath();
        t_linear();
        t_lock();
        report_and_stop();
    end
endmodule
